// File: design/pdt_top.sv
// prescaler, interval timer A and reload timer B behind an APB slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - prescaler is an 11-bit up-counter stepping every system clock
// - prescaler clears on reset, counts after release, halts in stop mode
// - prescaler taps feed timer A and timer B
// - timer A counts selected ticks, wraps FF to 00 with an overflow
// - timer A overflow sets its request flag, address 1 bit 2
// - 3-bit timer A select picks divide 2048, 1024, 512, 128 or 32 for codes 0 to 4; codes 5 to 7 use TA_LOG_5..TA_LOG_7
// - both mode registers clear on reset, selecting divide 2048, no reload
// - timer B mode bit 3 enables auto-reload
// - timer B mode bits 2..0 pick its tap or the external event input
// - timer B mode write takes effect two cycles later
// - timer B overflows after FF, reloading or going to zero
// - timer B overflow sets its request flag, address 2 bit 0
// - load value written low then high; high write loads the counter
// - load register clears on reset
// - reading count high nibble latches low nibble for the next read
// - counter reads and load writes share addresses A and B
// - mask bits at address 1 bit 3 and address 2 bit 1 block requests
module pdt_top
   import pdt_pkg::*;
#(
   parameter logic [3:0] TA_LOG_5 = 4'h3,
   parameter logic [3:0] TA_LOG_6 = 4'h2,
   parameter logic [3:0] TA_LOG_7 = 4'h1,
   parameter logic [3:0] TB_LOG_4 = 4'h3,
   parameter logic [3:0] TB_LOG_5 = 4'h2,
   parameter logic [3:0] TB_LOG_6 = 4'h1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device pins and status
   input wire logic stop_mode,
   input wire logic ext_event_input,
   output logic [PRE_W-1:0] presc_count,
   output logic irq
);
   typedef struct packed {
      logic [2:0] ta_sel;
      logic [3:0] tb_mode;
      logic [3:0] tb_pend;
      logic [1:0] tb_dly;
      logic [CNT_W-1:0] ta_cnt;
      logic [CNT_W-1:0] tb_cnt;
      logic [CNT_W-1:0] reload;
      logic [NIB_W-1:0] rd_latch;
      logic flag_a;
      logic flag_b;
      logic mask_a;
      logic mask_b;
      logic ev_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pdt_state_t;

   pdt_state_t st_r;
   pdt_state_t st_nxt;

   logic [PRE_W:1] tick;
   logic [3:0] ta_log;
   logic [3:0] tb_log;
   logic ta_tick;
   logic tb_tick;
   logic ev_fall;
   logic ovf_a;
   logic ovf_b;
   logic [WORD_W-1:0] word;
   logic hit_ia;
   logic hit_ib;
   logic hit_tas;
   logic hit_tbm;
   logic hit_lo;
   logic hit_hi;
   logic mapped;
   logic cap;
   logic done;
   logic wr;
   logic [31:0] rd_mux;

   pdt_prescaler #(
      .PW(PRE_W)
   ) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .halt(stop_mode),
      .count(presc_count),
      .tick(tick)
   );

   // tap choice per mode code
   always_comb begin
      unique case (st_r.ta_sel)
         3'h0: ta_log = LOG_2048;
         3'h1: ta_log = LOG_1024;
         3'h2: ta_log = LOG_512;
         3'h3: ta_log = LOG_128;
         3'h4: ta_log = LOG_32;
         3'h5: ta_log = TA_LOG_5;
         3'h6: ta_log = TA_LOG_6;
         3'h7: ta_log = TA_LOG_7;
      endcase
   end

   always_comb begin
      unique case (st_r.tb_mode[2:0])
         3'h0: tb_log = LOG_2048;
         3'h1: tb_log = LOG_512;
         3'h2: tb_log = LOG_128;
         3'h3: tb_log = LOG_32;
         3'h4: tb_log = TB_LOG_4;
         3'h5: tb_log = TB_LOG_5;
         3'h6: tb_log = TB_LOG_6;
         3'h7: tb_log = LOG_2048;
      endcase
   end

   // the event pin is active low, so a falling edge is one event
   assign ev_fall = st_r.ev_prev & ~ext_event_input & ~stop_mode;
   assign ta_tick = tick[ta_log];
   assign tb_tick = (st_r.tb_mode[2:0] == TB_EXT_CODE) ? ev_fall : tick[tb_log];
   assign ovf_a = ta_tick & (&st_r.ta_cnt);
   assign ovf_b = tb_tick & (&st_r.tb_cnt);

   // apb decode
   assign word = paddr[ADDR_W-1:2];
   assign hit_ia = (word == WORD_W'(IDX_IRQ_A));
   assign hit_ib = (word == WORD_W'(IDX_IRQ_B));
   assign hit_tas = (word == WORD_W'(IDX_TA_SEL));
   assign hit_tbm = (word == WORD_W'(IDX_TB_MODE));
   assign hit_lo = (word == WORD_W'(IDX_TB_LOW));
   assign hit_hi = (word == WORD_W'(IDX_TB_HIGH));
   assign mapped = hit_ia | hit_ib | hit_tas | hit_tbm | hit_lo | hit_hi;
   // first access cycle fetches read data, second completes the transfer
   assign cap = psel & penable & ~st_r.pready;
   assign done = psel & penable & st_r.pready;
   // a write with lane 0 off stores nothing, since every field is in lane 0
   assign wr = done & pwrite & pstrb[0] & mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ia) begin
         rd_mux[FLAG_A_BIT] = st_r.flag_a;
         rd_mux[MASK_A_BIT] = st_r.mask_a;
      end
      if (hit_ib) begin
         rd_mux[FLAG_B_BIT] = st_r.flag_b;
         rd_mux[MASK_B_BIT] = st_r.mask_b;
      end
      if (hit_lo) begin
         rd_mux[NIB_W-1:0] = st_r.rd_latch;
      end
      if (hit_hi) begin
         rd_mux[NIB_W-1:0] = st_r.tb_cnt[CNT_W-1:NIB_W];
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ev_prev = ext_event_input;

      // bus handshake
      if (cap) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = ~mapped;
         st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_mux;
         if (hit_hi && !pwrite) begin
            st_nxt.rd_latch = st_r.tb_cnt[NIB_W-1:0];
         end
      end
      if (done) begin
         st_nxt.pready = 1'b0;
      end

      // timer A is free running
      if (ta_tick) begin
         st_nxt.ta_cnt = st_r.ta_cnt + CNT_W'(1);
      end

      // timer B counts, then overflows to reload or zero
      if (tb_tick) begin
         if (ovf_b) begin
            st_nxt.tb_cnt = st_r.tb_mode[RELOAD_EN_BIT] ? st_r.reload : CNT_RST;
         end else begin
            st_nxt.tb_cnt = st_r.tb_cnt + CNT_W'(1);
         end
      end

      // delayed timer B mode
      st_nxt.tb_dly = {st_r.tb_dly[0], 1'b0};
      if (st_r.tb_dly[1]) begin
         st_nxt.tb_mode = st_r.tb_pend;
      end

      // register writes
      if (wr) begin
         if (hit_ia) begin
            st_nxt.mask_a = pwdata[MASK_A_BIT];
            if (pwdata[FLAG_A_BIT]) begin
               st_nxt.flag_a = 1'b0;
            end
         end
         if (hit_ib) begin
            st_nxt.mask_b = pwdata[MASK_B_BIT];
            if (pwdata[FLAG_B_BIT]) begin
               st_nxt.flag_b = 1'b0;
            end
         end
         if (hit_tas) begin
            st_nxt.ta_sel = pwdata[2:0];
         end
         if (hit_tbm) begin
            st_nxt.tb_pend = pwdata[3:0];
            st_nxt.tb_dly = TB_DLY_START;
         end
         if (hit_lo) begin
            st_nxt.reload[NIB_W-1:0] = pwdata[NIB_W-1:0];
         end
         if (hit_hi) begin
            // the load beats a same-cycle count or overflow
            st_nxt.reload[CNT_W-1:NIB_W] = pwdata[NIB_W-1:0];
            st_nxt.tb_cnt = {pwdata[NIB_W-1:0], st_r.reload[NIB_W-1:0]};
         end
      end

      // set wins over a same-cycle clear
      if (ovf_a) begin
         st_nxt.flag_a = 1'b1;
      end
      if (ovf_b) begin
         st_nxt.flag_b = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.ta_sel <= TA_SEL_RST;
         st_r.tb_mode <= TB_MODE_RST;
         st_r.tb_pend <= TB_MODE_RST;
         st_r.tb_dly <= 2'h0;
         st_r.ta_cnt <= CNT_RST;
         st_r.tb_cnt <= CNT_RST;
         st_r.reload <= RELOAD_RST;
         st_r.rd_latch <= NIB_RST;
         st_r.flag_a <= FLAG_RST;
         st_r.flag_b <= FLAG_RST;
         st_r.mask_a <= MASK_RST;
         st_r.mask_b <= MASK_RST;
         st_r.ev_prev <= 1'b1;
         st_r.pready <= 1'b0;
         st_r.pslverr <= 1'b0;
         st_r.prdata <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr & st_r.pready;
   // a mask of one blocks its flag
   assign irq = (st_r.flag_a & ~st_r.mask_a) | (st_r.flag_b & ~st_r.mask_b);

   // checks
   logic wr_tbm;
   logic wr_hi;
   assign wr_tbm = wr & hit_tbm;
   assign wr_hi = wr & hit_hi;

   // the edge that releases reset still finds the counter held, so it is skipped
   a_presc_step: assert property (@(posedge pclk) disable iff (!presetn)
      !stop_mode && $past(presetn) |=> presc_count == $past(presc_count) + PRE_W'(1))
      else $error("prescaler did not step");

   a_presc_hold: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode |=> $stable(presc_count))
      else $error("prescaler moved in stop mode");

   a_ta_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_a |=> st_r.ta_cnt == CNT_RST && st_r.flag_a)
      else $error("timer A did not wrap with flag");

   a_ta_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_r.flag_a) |-> $past(ovf_a))
      else $error("timer A flag set without overflow");

   a_ta_div_slow: assert property (@(posedge pclk) disable iff (!presetn)
      ta_tick && st_r.ta_sel == 3'h0 |-> presc_count == 11'h7FF)
      else $error("timer A tap wrong for code 0");

   a_modes_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> st_r.ta_sel == TA_SEL_RST && st_r.tb_mode == TB_MODE_RST)
      else $error("mode registers not cleared");

   a_tb_reload: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_b && !wr_hi && st_r.tb_mode[RELOAD_EN_BIT] |=> st_r.tb_cnt == $past(st_r.reload))
      else $error("timer B did not reload");

   a_tb_no_reload: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_b && !wr_hi && !st_r.tb_mode[RELOAD_EN_BIT] |=> st_r.tb_cnt == CNT_RST)
      else $error("timer B did not clear on overflow");

   a_ta_count: assert property (@(posedge pclk) disable iff (!presetn)
      ta_tick && !ovf_a |=> st_r.ta_cnt == $past(st_r.ta_cnt) + CNT_W'(1))
      else $error("timer A did not step on its tick");

   a_tb_ext_clk: assert property (@(posedge pclk) disable iff (!presetn)
      tb_tick && st_r.tb_mode[2:0] == TB_EXT_CODE |-> $past(ext_event_input) && !ext_event_input)
      else $error("external count without falling edge");

   a_tb_mode_delay: assert property (@(posedge pclk) disable iff (!presetn)
      wr_tbm |-> ##3 st_r.tb_mode == $past(pwdata[3:0], 3))
      else $error("timer B mode delay wrong");

   a_tb_flag_win: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_b |=> st_r.flag_b)
      else $error("timer B flag lost");

   a_load_high: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hi |=> st_r.tb_cnt == {$past(pwdata[3:0]), $past(st_r.reload[3:0])})
      else $error("high nibble write did not load counter");

   a_read_latch: assert property (@(posedge pclk) disable iff (!presetn)
      cap && hit_hi && !pwrite |=> st_r.rd_latch == $past(st_r.tb_cnt[3:0]))
      else $error("low nibble not latched");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      cap |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   c_ta_ovf: cover property (@(posedge pclk) disable iff (!presetn) ovf_a);
   c_tb_reload: cover property (@(posedge pclk) disable iff (!presetn)
      ovf_b && st_r.tb_mode[RELOAD_EN_BIT]);
   c_tb_ext: cover property (@(posedge pclk) disable iff (!presetn)
      tb_tick && st_r.tb_mode[2:0] == TB_EXT_CODE);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : pdt_top

// File: design/pdt_pkg.sv
// constants shared by the prescaler dual-timer design
package pdt_pkg;
   // sizes
   localparam int PRE_W = 11;
   localparam int CNT_W = 8;
   localparam int NIB_W = 4;
   localparam int ADDR_W = 12;
   localparam int WORD_W = ADDR_W - 2;

   // register indices; the byte address is four times the index
   localparam logic [3:0] IDX_IRQ_A = 4'h1;
   localparam logic [3:0] IDX_IRQ_B = 4'h2;
   localparam logic [3:0] IDX_TA_SEL = 4'h8;
   localparam logic [3:0] IDX_TB_MODE = 4'h9;
   localparam logic [3:0] IDX_TB_LOW = 4'hA;
   localparam logic [3:0] IDX_TB_HIGH = 4'hB;

   // field positions
   localparam int FLAG_A_BIT = 2;
   localparam int MASK_A_BIT = 3;
   localparam int FLAG_B_BIT = 0;
   localparam int MASK_B_BIT = 1;
   localparam int RELOAD_EN_BIT = 3;

   // reset values
   localparam logic [PRE_W-1:0] PRE_RST = 11'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [2:0] TA_SEL_RST = 3'h0;
   localparam logic [3:0] TB_MODE_RST = 4'h0;
   localparam logic [CNT_W-1:0] RELOAD_RST = 8'h00;
   localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
   localparam logic FLAG_RST = 1'b0;
   localparam logic MASK_RST = 1'b1;

   // prescaler taps as log2 of the divide ratio
   localparam logic [3:0] LOG_2048 = 4'hB;
   localparam logic [3:0] LOG_1024 = 4'hA;
   localparam logic [3:0] LOG_512 = 4'h9;
   localparam logic [3:0] LOG_128 = 4'h7;
   localparam logic [3:0] LOG_32 = 4'h5;

   // timer B clock code that selects the external event input
   localparam logic [2:0] TB_EXT_CODE = 3'h7;

   // mode delay shift: a write lands on the second cycle after it
   localparam logic [1:0] TB_DLY_START = 2'h1;
endpackage : pdt_pkg

// File: design/pdt_prescaler.sv
// free-running prescaler with one divide tick per bit
`timescale 1ns/10ps
module pdt_prescaler
   import pdt_pkg::*;
#(
   parameter int PW = PRE_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic halt,
   // outputs
   output logic [PW-1:0] count,
   output logic [PW:1] tick
);
   typedef struct packed {
      logic [PW-1:0] cnt;
   } pdt_pre_t;

   pdt_pre_t st_r;
   pdt_pre_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!halt) begin
         st_nxt.cnt = st_r.cnt + PW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.cnt <= PW'(PRE_RST);
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.cnt;

   // tick k marks the edge that closes a period of 2**k clocks
   genvar k;
   generate
      for (k = 1; k <= PW; k++) begin : g_tap
         assign tick[k] = ~halt & (&st_r.cnt[k-1:0]);
      end
   endgenerate
endmodule : pdt_prescaler

// File: bench/pdt_event_src.sv
// partner model of the external event pin, driven on request of the bench
`timescale 1ns/10ps
module pdt_event_src (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from the bench
   input wire logic go,
   input wire logic [3:0] n_events,
   // pin side
   output logic ext_event_input,
   output logic busy
);
   logic [3:0] left_r;
   logic [1:0] ph_r;
   // pin is active low and idles high; each pulse is two cycles low, two high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_event_input <= 1'b1;
         busy <= 1'b0;
         left_r <= 4'h0;
         ph_r <= 2'h0;
      end else if (go && !busy) begin
         left_r <= n_events;
         busy <= (n_events != 4'h0);
         ph_r <= 2'h0;
      end else if (busy) begin
         ext_event_input <= ph_r[1];
         ph_r <= ph_r + 2'h1;
         if (ph_r == 2'h3) begin
            left_r <= left_r - 4'h1;
            busy <= (left_r != 4'h1);
         end
      end
   end
endmodule : pdt_event_src

// File: bench/pdt_tb_top.sv
// self-checking bench for the prescaler dual-timer block
`timescale 1ns/10ps
module pdt_tb_top
   import pdt_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic stop_mode = 1'b0;
   logic go = 1'b0;
   logic [3:0] n_events = 4'h0;
   logic ext_event_input;
   logic busy;
   logic [PRE_W-1:0] presc_count;
   logic irq;
   logic [31:0] rd;
   logic err;
   logic [PRE_W-1:0] snap;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   always #2 pclk = ~pclk;

   pdt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
      .ext_event_input(ext_event_input), .presc_count(presc_count), .irq(irq));

   pdt_event_src i_src (.pclk(pclk), .presetn(presetn), .go(go), .n_events(n_events),
      .ext_event_input(ext_event_input), .busy(busy));

   task automatic complete_run;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // one apb transfer; the slave's answer time is waited for, not assumed
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [3:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {6'h00, idx, 2'h0};
      pwdata <= {28'h0000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic events(input logic [3:0] n);
      @(posedge pclk);
      n_events <= n;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do begin
         @(posedge pclk);
      end while (busy === 1'b1);
      repeat (4) @(posedge pclk);
   endtask : events

   task automatic read_count(input logic [7:0] exp);
      apb(1'b0, IDX_TB_HIGH, 4'h0);
      chk(rd, {28'h0000000, exp[7:4]}, "count high");
      apb(1'b0, IDX_TB_LOW, 4'h0);
      chk(rd, {28'h0000000, exp[3:0]}, "count low");
   endtask : read_count

   task automatic t_reset_values;
      chk(32'(presc_count), 32'h0000_0000, "prescaler after reset");
      apb(1'b0, IDX_IRQ_A, 4'h0);
      chk(rd, 32'h0000_0008, "timer a flag and mask");
      apb(1'b0, IDX_IRQ_B, 4'h0);
      chk(rd, 32'h0000_0002, "timer b flag and mask");
      apb(1'b0, IDX_TA_SEL, 4'h0);
      chk(rd, 32'h0000_0000, "write-only select reads zero");
      apb(1'b0, 4'h3, 4'h0);
      chk({31'h0, err}, 32'h0000_0001, "unmapped index error");
      read_count(8'h00);
   endtask : t_reset_values

   // reload on: FE, FF, overflow back to FE; reload off: overflow to 00
   task automatic t_timer_b(input logic reload, input logic [7:0] exp);
      apb(1'b1, IDX_IRQ_B, 4'h1);
      apb(1'b1, IDX_TB_MODE, {reload, TB_EXT_CODE});
      repeat (4) @(posedge pclk);
      apb(1'b1, IDX_TB_LOW, 4'hE);
      apb(1'b1, IDX_TB_HIGH, 4'hF);
      read_count(8'hFE);
      events(4'h2);
      read_count(exp);
      chk({31'h0, irq}, 32'h0000_0001, "timer b request");
      apb(1'b0, IDX_IRQ_B, 4'h0);
      chk(rd, 32'h0000_0001, "timer b flag set");
      apb(1'b1, IDX_IRQ_B, 4'h3);
      // the write lands on the completion edge, so look one edge later
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000, "masked and cleared");
   endtask : t_timer_b

   task automatic t_timer_a;
      int n;
      apb(1'b1, IDX_TA_SEL, 4'h7);
      apb(1'b1, IDX_IRQ_A, 4'h4);
      n = 0;
      while (irq !== 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, irq}, 32'h0000_0001, "timer a overflow request");
      apb(1'b0, IDX_IRQ_A, 4'h0);
      chk(rd, 32'h0000_0004, "timer a flag set");
      apb(1'b1, IDX_IRQ_A, 4'h8);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000, "timer a masked");
      apb(1'b1, IDX_IRQ_A, 4'hC);
      apb(1'b0, IDX_IRQ_A, 4'h0);
      chk(rd, 32'h0000_0008, "timer a flag cleared");
   endtask : t_timer_a

   task automatic t_prescaler;
      @(posedge pclk);
      snap = presc_count + 11'h001;
      @(posedge pclk);
      chk(32'(presc_count), 32'(snap), "prescaler step");
      stop_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      snap = presc_count;
      repeat (5) @(posedge pclk);
      chk(32'(presc_count), 32'(snap), "prescaler frozen in stop");
      stop_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, presc_count != snap}, 32'h0000_0001, "prescaler resumes");
   endtask : t_prescaler

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_timer_b(1'b1, 8'hFE);
      t_timer_b(1'b0, 8'h00);
      t_timer_a();
      t_prescaler();
      complete_run();
   end
endmodule : pdt_tb_top
